// ==== rtl/prc_map.svh ====
// Register map, field positions and timing figures of the reset controller
// Assumes inclusion by bare name from the design file
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PRC_ADDR_CORE_CTRL   16'h0000
`define PRC_ADDR_SUB_RESET   16'hff0c
`define PRC_ADDR_RESTRAP_EN  16'hff0d
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PRC_CORE_RESET_BIT   15
`define PRC_SOFT_PD_BIT      11
`define PRC_SUB_RESET_BIT    0
`define PRC_RESTRAP_EN_BIT   0
// ----------------------------------------------------------------------
// Reset values and clock select codes
// ----------------------------------------------------------------------
`define PRC_RESTRAP_EN_RST   1'h0
`define PRC_GPSEL_OFF        2'h0
`define PRC_GPSEL_125        2'h1
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PRC_CLK_PERIOD_NS    10
`define PRC_ACCESS_WAIT_NS   5000000
`define PRC_HOLD_CYC         16
`endif

// ==== rtl/prc_pkg.sv ====
// Types shared by the reset and power-down controller
// Assumes prc_map.svh alongside for the numeric constants
package prc_pkg;
  // ----------------------------------------------------------------------
  // Sequencer states and reset kinds
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PRC_ST_PWRUP,
    PRC_ST_HOLD,
    PRC_ST_RUN
  } prc_state_type;

  typedef enum logic [1:0] {
    PRC_KIND_HW,
    PRC_KIND_RESTRAP,
    PRC_KIND_SUB,
    PRC_KIND_CORE
  } prc_kind_type;

  // ----------------------------------------------------------------------
  // Management access request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } prc_mgmt_req_type;

  // ----------------------------------------------------------------------
  // Controls toward the rest of the chip
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic xtal_en;
    logic cmu_reset;
    logic cmu_en;
    logic general_clock_out_en;
    logic mac_if_reset;
    logic core_reset;
    logic sub_reset;
    logic mac_oe_n;
    logic mac_idle;
    logic link_enable;
  } prc_ctl_type;
endpackage

// ==== rtl/prc_top.sv ====
// Reset and power-down sequencer with its three management registers
// Assumes rst_n is the deglitched hardware reset path, already on ref_clk
//
// Notes on behaviour
// - Restrap reset needs restrap enable written 1, then subsystem reset bit.
// - Restrap reset runs hardware sequence minus oscillator stop and settle wait.
// - Restrap reset re-latches straps; they set pin-dependent register defaults.
// - Restrap resets MAC block, core; multiplier too unless 125 MHz selected.
// - Restrap reset returns restrap enable to zero.
// - General clock output is off during a restrap reset.
// - Subsystem reset bit starts a subsystem reset and clears itself after.
// - Plain subsystem reset resets registers, MAC block, core; no strap resample.
// - Plain subsystem and core resets spare multiplier when 125 MHz selected.
// - General clock keeps running through plain subsystem and core resets.
// - Core reset bit resets core and its registers, self-clears.
// - Core reset leaves the MAC interface block alone.
// - No software reset stops the crystal oscillator.
// - Reset pin low means hardware power-down: all stopped, no access.
// - Hardware power-down tristates MAC outputs and disables general clock.
// - Power-down bit set enters software power-down; default from straps.
// - Software power-down ignores line, no link, registers stay reachable.
// - Software power-down holds MAC outputs idle, receive clock high.
// - With 125 MHz selected the multiplier stays on in power-down.
// - Clearing the power-down bit starts link bring-up.
// - Any core reset forces MAC outputs to idle state.
// - Registers reachable no later than 5 ms after reset release.
`timescale 1ns/1ps
`include "prc_map.svh"
module prc_top #(
  parameter int WAIT_CYC = `PRC_ACCESS_WAIT_NS / `PRC_CLK_PERIOD_NS,
  parameter int HOLD_CYC = `PRC_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // Strap pins
  input  wire logic                     link_indicator_strap_pin,
  input  wire logic                     led_strap_pin,
  // General clock select, from the clock block
  input  wire logic [1:0]               general_clock_out_sel,
  // Management register port
  input  wire prc_pkg::prc_mgmt_req_type mgmt_req,
  output logic [15:0]                   mgmt_rdata,
  output logic                          mgmt_ack,
  output logic                          mgmt_ready,
  // Controls and latched straps
  output prc_pkg::prc_ctl_type          ctl,
  output logic [1:0]                    strap_latched
);
  localparam int CW = $clog2(WAIT_CYC + 1);

  // Power-up needs at least one cycle before the hold
  if (WAIT_CYC < 2 || HOLD_CYC < 1 || HOLD_CYC >= WAIT_CYC) begin : g_chk
    $error("prc_top: bad WAIT_CYC or HOLD_CYC");
  end

  // ----------------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------------
  logic [1:0] s1_r, s2_r, s3_r, strap_f_r, strap_r;
  always_ff @(posedge ref_clk) begin
    s1_r <= {link_indicator_strap_pin, led_strap_pin};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  // Filtered level, moves only when the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_f_r <= 2'h0;
    end else if (s2_r == s3_r) begin
      strap_f_r <= s3_r;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  prc_pkg::prc_state_type state_r;
  prc_pkg::prc_kind_type  kind_r;
  logic [CW-1:0]          cnt_r;
  logic                   pd_r, ren_r, run, wr_ok, hold_end;
  logic                   wr_ctrl, wr_sub, wr_ren, go_core, go_sub;

  assign run      = state_r == prc_pkg::PRC_ST_RUN;
  assign wr_ok    = run && mgmt_req.wr;
  assign wr_ctrl  = wr_ok && mgmt_req.addr == `PRC_ADDR_CORE_CTRL;
  assign wr_sub   = wr_ok && mgmt_req.addr == `PRC_ADDR_SUB_RESET;
  assign wr_ren   = wr_ok && mgmt_req.addr == `PRC_ADDR_RESTRAP_EN;
  assign go_core  = wr_ctrl && mgmt_req.wdata[`PRC_CORE_RESET_BIT];
  assign go_sub   = wr_sub && mgmt_req.wdata[`PRC_SUB_RESET_BIT];
  assign hold_end = state_r == prc_pkg::PRC_ST_HOLD
                    && cnt_r == CW'(HOLD_CYC - 1);

  // Counts on ref_clk, which keeps running while the multiplier resets
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= prc_pkg::PRC_ST_PWRUP;
      kind_r  <= prc_pkg::PRC_KIND_HW;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        prc_pkg::PRC_ST_PWRUP: begin
          // Oscillator settle wait; counted once per release
          cnt_r <= cnt_r + CW'(1);
          if (cnt_r == CW'(WAIT_CYC - HOLD_CYC - 1)) begin
            state_r <= prc_pkg::PRC_ST_HOLD;
            cnt_r   <= '0;
          end
        end
        prc_pkg::PRC_ST_HOLD: begin
          cnt_r <= cnt_r + CW'(1);
          if (hold_end) begin
            state_r <= prc_pkg::PRC_ST_RUN;
            cnt_r   <= '0;
          end
        end
        prc_pkg::PRC_ST_RUN: begin
          if (go_sub) begin
            // Restrap skips the settle wait entirely
            state_r <= prc_pkg::PRC_ST_HOLD;
            kind_r  <= ren_r ? prc_pkg::PRC_KIND_RESTRAP
                             : prc_pkg::PRC_KIND_SUB;
          end else if (go_core) begin
            state_r <= prc_pkg::PRC_ST_HOLD;
            kind_r  <= prc_pkg::PRC_KIND_CORE;
          end
        end
        default: state_r <= prc_pkg::PRC_ST_PWRUP;
      endcase
    end
  end

  // Strap latch at the start of a hardware or restrap hold
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_r <= 2'h0;
    end else if (state_r == prc_pkg::PRC_ST_PWRUP
                 && cnt_r == CW'(WAIT_CYC - HOLD_CYC - 1)) begin
      strap_r <= strap_f_r;
    end else if (go_sub && ren_r) begin
      strap_r <= strap_f_r;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Power-down default taken when both straps are high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pd_r <= 1'h0;
    end else if (hold_end) begin
      pd_r <= &strap_r;
    end else if (wr_ctrl && !go_core) begin
      pd_r <= mgmt_req.wdata[`PRC_SOFT_PD_BIT];
    end
  end

  // Subsystem register: cleared by every reset that touches subsystem
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ren_r <= `PRC_RESTRAP_EN_RST;
    end else if (hold_end && kind_r != prc_pkg::PRC_KIND_CORE) begin
      ren_r <= `PRC_RESTRAP_EN_RST;
    end else if (wr_ren) begin
      ren_r <= mgmt_req.wdata[`PRC_RESTRAP_EN_BIT];
    end
  end

  // Read mux; reset bits read 1 until their reset is done
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    case (mgmt_req.addr)
      `PRC_ADDR_CORE_CTRL: begin
        rd_val[`PRC_CORE_RESET_BIT] = !run
                                      && kind_r == prc_pkg::PRC_KIND_CORE;
        rd_val[`PRC_SOFT_PD_BIT]    = pd_r;
      end
      `PRC_ADDR_SUB_RESET: begin
        rd_val[`PRC_SUB_RESET_BIT] = !run
          && (kind_r == prc_pkg::PRC_KIND_SUB
              || kind_r == prc_pkg::PRC_KIND_RESTRAP);
      end
      `PRC_ADDR_RESTRAP_EN: rd_val[`PRC_RESTRAP_EN_BIT] = ren_r;
      default: rd_val = 16'h0000;
    endcase
  end

  // No access during the power-up wait; writes in a hold are dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
      mgmt_ack   <= 1'h0;
    end else begin
      mgmt_ack <= (mgmt_req.rd || mgmt_req.wr)
                  && state_r != prc_pkg::PRC_ST_PWRUP;
      if (mgmt_req.rd && state_r != prc_pkg::PRC_ST_PWRUP) begin
        mgmt_rdata <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  logic hw, rs, sw, sel125, gp_on;
  prc_pkg::prc_ctl_type ctl_nxt;
  assign hw     = state_r == prc_pkg::PRC_ST_PWRUP
                  || (state_r == prc_pkg::PRC_ST_HOLD
                      && kind_r == prc_pkg::PRC_KIND_HW);
  assign rs     = state_r == prc_pkg::PRC_ST_HOLD
                  && kind_r == prc_pkg::PRC_KIND_RESTRAP;
  assign sw     = state_r == prc_pkg::PRC_ST_HOLD && !hw;
  assign sel125 = general_clock_out_sel == `PRC_GPSEL_125;
  assign gp_on  = general_clock_out_sel != `PRC_GPSEL_OFF;

  always_comb begin
    ctl_nxt              = '0;
    ctl_nxt.xtal_en      = 1'h1;
    ctl_nxt.cmu_reset    = hw || (sw && !sel125);
    ctl_nxt.cmu_en       = !ctl_nxt.cmu_reset
                           && (sel125 || (run && !pd_r));
    ctl_nxt.general_clock_out_en    = gp_on && !hw && !rs;
    ctl_nxt.mac_if_reset = hw || rs
                           || (sw && kind_r == prc_pkg::PRC_KIND_SUB);
    ctl_nxt.sub_reset    = ctl_nxt.mac_if_reset;
    ctl_nxt.core_reset   = !run;
    ctl_nxt.mac_oe_n     = 1'h0;
    ctl_nxt.mac_idle     = !run || pd_r;
    ctl_nxt.link_enable  = run && !pd_r;
  end

  // Reset values are the hardware power-down pin state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl               <= '0;
      ctl.mac_oe_n      <= 1'h1;
      ctl.core_reset    <= 1'h1;
      ctl.mac_if_reset  <= 1'h1;
      ctl.sub_reset     <= 1'h1;
      ctl.cmu_reset     <= 1'h1;
      mgmt_ready        <= 1'h0;
      strap_latched     <= 2'h0;
    end else begin
      ctl               <= ctl_nxt;
      mgmt_ready        <= state_r != prc_pkg::PRC_ST_PWRUP;
      strap_latched     <= strap_r;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_restrap_clr;
    hold_end && kind_r == prc_pkg::PRC_KIND_RESTRAP |=> !ren_r;
  endproperty
  a_restrap_clr: assert property (p_restrap_clr)
    else $error("restrap enable not cleared");

  property p_restrap_gp;
    rs |=> !ctl.general_clock_out_en && ctl.mac_if_reset && ctl.xtal_en;
  endproperty
  a_restrap_gp: assert property (p_restrap_gp)
    else $error("general clock live in restrap reset");

  property p_core_mac;
    sw && kind_r == prc_pkg::PRC_KIND_CORE
      |=> !ctl.mac_if_reset && ctl.core_reset && ctl.mac_idle;
  endproperty
  a_core_mac: assert property (p_core_mac)
    else $error("core reset touched MAC block");

  property p_gp_kept;
    sw && !rs && gp_on |=> ctl.general_clock_out_en && ctl.xtal_en;
  endproperty
  a_gp_kept: assert property (p_gp_kept)
    else $error("general clock dropped in soft reset");

  property p_cmu_keep;
    sw && sel125 |=> !ctl.cmu_reset && ctl.cmu_en;
  endproperty
  a_cmu_keep: assert property (p_cmu_keep)
    else $error("multiplier reset with 125 MHz selected");

  property p_self_clr;
    go_sub || go_core |=> !run [*1] ##[1:300] run;
  endproperty
  a_self_clr: assert property (p_self_clr)
    else $error("reset bit did not self clear");

  property p_pd_idle;
    run && pd_r |=> ctl.mac_idle && !ctl.link_enable;
  endproperty
  a_pd_idle: assert property (p_pd_idle)
    else $error("power-down outputs not idle");

  property p_pd_cmu;
    run && pd_r && sel125 |=> ctl.cmu_en;
  endproperty
  a_pd_cmu: assert property (p_pd_cmu)
    else $error("multiplier off with 125 MHz in power-down");

  property p_hw_pd;
    $rose(rst_n) |-> ctl.mac_oe_n && !ctl.general_clock_out_en && !mgmt_ready;
  endproperty
  a_hw_pd: assert property (p_hw_pd)
    else $error("hardware power-down state wrong");

  property p_wake;
    $fell(pd_r) && run |=> ctl.link_enable;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no bring-up after power-down cleared");

  c_restrap: cover property (go_sub && ren_r);
  c_sub:     cover property (go_sub && !ren_r);
  c_core:    cover property (go_core ##[1:300] run);
  c_pd:      cover property (run && pd_r);
endmodule

// ==== bench/prc_host.sv ====
// Host model for the management port of the reset controller
// Assumes falling-edge launch and the device's one-cycle request pulses
`timescale 1ns/1ps
module prc_host (
  // Clock and device status
  input  wire logic                 ref_clk,
  input  wire logic                 mgmt_ready,
  input  wire logic                 mgmt_ack,
  // Request toward the device
  output prc_pkg::prc_mgmt_req_type mgmt_req
);
  // ------------------------------------------------------------
  // Requests and expected-result notes
  // ------------------------------------------------------------
  logic [16:0] note_q[$];

  initial mgmt_req = '0;

  // Pulse only: a held strobe would be taken a second time
  task automatic access(input logic rd, input logic [15:0] addr,
                        input logic [15:0] data);
    int n;
    n = 0;
    while (mgmt_ready !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    note_q.push_back({rd, data});
    mgmt_req <= {~rd, rd, addr, rd ? 16'h0000 : data};
    @(negedge ref_clk);
    mgmt_req <= '0;
    n = 0;
    while (mgmt_ack !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    // Idle gap, so a following call never re-drives the strobe this step
    @(negedge ref_clk);
  endtask

  // Read while the device is unreachable; no note, no ack awaited
  task automatic refused();
    mgmt_req <= {1'b0, 1'b1, 16'h0000, 16'h0000};
    @(negedge ref_clk);
    mgmt_req <= '0;
  endtask
endmodule

// ==== bench/prc_top_tb.sv ====
// Self-checking bench for the reset and power-down controller
// Assumes the host model beside it and shortened power-up counts
`timescale 1ns/1ps
module prc_top_tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam int WAIT = 40;
  localparam int HOLD = 4;
  logic                      ref_clk;
  logic                      rst_n;
  logic [1:0]                strap;
  logic [1:0]                general_clock_out_sel;
  logic [1:0]                strap_latched;
  logic [1:0]                s;
  logic [15:0]               mgmt_rdata;
  logic                      mgmt_ack;
  logic                      mgmt_ready;
  logic [16:0]               note;
  prc_pkg::prc_mgmt_req_type mgmt_req;
  prc_pkg::prc_ctl_type      ctl;
  int                        fail_count;
  int                        total_checks;
  int                        cycles;

  prc_top #(.WAIT_CYC(WAIT), .HOLD_CYC(HOLD)) prc_top_i (
    .ref_clk                  (ref_clk),
    .rst_n                    (rst_n),
    .link_indicator_strap_pin (strap[1]),
    .led_strap_pin            (strap[0]),
    .general_clock_out_sel               (general_clock_out_sel),
    .mgmt_req                 (mgmt_req),
    .mgmt_rdata               (mgmt_rdata),
    .mgmt_ack                 (mgmt_ack),
    .mgmt_ready               (mgmt_ready),
    .ctl                      (ctl),
    .strap_latched            (strap_latched)
  );

  prc_host prc_host_i (
    .ref_clk    (ref_clk),
    .mgmt_ready (mgmt_ready),
    .mgmt_ack   (mgmt_ack),
    .mgmt_req   (mgmt_req)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({15'h0, seen}, {15'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    prc_host_i.access(1'b0, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    prc_host_i.access(1'b1, a, e);
  endtask

  task automatic complete_run();
    check(16'(prc_host_i.note_q.size()), 16'h0000);
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset held six cycles; an early read must go unanswered
  task automatic power_cycle();
    int n;
    rst_n = 1'b0;
    cyc(2);
    chk1(ctl.mac_oe_n, 1'b1);
    chk1(ctl.general_clock_out_en, 1'b0);
    chk1(ctl.cmu_en, 1'b0);
    chk1(ctl.xtal_en, 1'b0);
    chk1(mgmt_ready, 1'b0);
    prc_host_i.refused();
    cyc(3);
    rst_n = 1'b1;
    prc_host_i.refused();
    n = 0;
    while (mgmt_ready !== 1'b1 && n < WAIT + 10) begin
      cyc(1);
      n++;
    end
    chk1(n <= WAIT, 1'b1);
    cyc(HOLD + 4);
  endtask

  // ------------------------------------------------------------
  // Clock, timeout and result monitor
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  always @(negedge ref_clk) begin
    if (mgmt_ack === 1'b1) begin
      if (prc_host_i.note_q.size() == 0) begin
        chk1(mgmt_ack, 1'b0);
      end else begin
        note = prc_host_i.note_q.pop_front();
        if (note[16] === 1'b1) begin
          check(mgmt_rdata, note[15:0]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    int k;
    int sel;
    rst_n = 1'b0;
    strap = 2'h3;
    general_clock_out_sel = 2'h0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(79114));
    power_cycle();
    check({14'h0, strap_latched}, 16'h0003);
    rd(16'h0000, 16'h0800);
    chk1(ctl.mac_idle, 1'b1);
    chk1(ctl.mac_oe_n, 1'b0);
    chk1(ctl.link_enable, 1'b0);
    general_clock_out_sel = 2'h1;
    cyc(3);
    chk1(ctl.cmu_en, 1'b1);
    rd(16'hff0d, 16'h0000);
    wr(16'h1234, 16'($urandom));
    rd(16'h1234, 16'h0000);
    wr(16'h0000, 16'h0000);
    cyc(3);
    chk1(ctl.link_enable, 1'b1);
    chk1(ctl.mac_idle, 1'b0);
    wr(16'h0000, 16'h0800);
    cyc(3);
    chk1(ctl.link_enable, 1'b0);
    rd(16'h0000, 16'h0800);
    $display("test power_up done");
    // Straps moved: plain resets must keep the earlier latch
    strap = 2'h0;
    for (k = 0; k < 2; k++) begin
      for (sel = 0; sel < 4; sel++) begin
        general_clock_out_sel = sel[1:0];
        wr(16'h0000, 16'h0000);
        if (k == 1 && sel == 0) begin
          wr(16'hff0d, 16'h0001);
        end
        if (k == 0) begin
          wr(16'hff0c, 16'h0001);
        end else begin
          wr(16'h0000, 16'h8000);
        end
        cyc(2);
        chk1(ctl.core_reset, 1'b1);
        chk1(ctl.mac_if_reset, k == 0);
        chk1(ctl.sub_reset, k == 0);
        chk1(ctl.cmu_reset, sel != 1);
        chk1(ctl.general_clock_out_en, sel != 0);
        chk1(ctl.xtal_en, 1'b1);
        chk1(ctl.mac_idle, 1'b1);
        cyc(HOLD + 6);
        rd(16'hff0c, 16'h0000);
        rd(16'h0000, 16'h0800);
        rd(16'hff0d, 16'(k));
        check({14'h0, strap_latched}, 16'h0003);
      end
    end
    $display("test soft_resets done");
    s = 2'($urandom_range(2, 0));
    strap = s;
    general_clock_out_sel = 2'h1;
    // Straps pass the synchroniser before the restrap takes them
    cyc(4);
    wr(16'hff0c, 16'h0001);
    cyc(2);
    chk1(ctl.general_clock_out_en, 1'b0);
    chk1(ctl.cmu_reset, 1'b0);
    chk1(ctl.mac_if_reset, 1'b1);
    chk1(ctl.xtal_en, 1'b1);
    cyc(HOLD + 6);
    check({14'h0, strap_latched}, {14'h0, s});
    rd(16'hff0d, 16'h0000);
    rd(16'h0000, {4'h0, &s, 11'h0});
    chk1(ctl.link_enable, 1'b1);
    strap = 2'h3;
    cyc(4);
    wr(16'hff0c, 16'h0001);
    cyc(HOLD + 6);
    check({14'h0, strap_latched}, {14'h0, s});
    $display("test restrap done");
    power_cycle();
    check({14'h0, strap_latched}, 16'h0003);
    rd(16'h0000, 16'h0800);
    $display("test hw_reset done");
    complete_run();
  end
endmodule
